// ===== src/asil_top.sv
// Alert status latches, enables and interrupt line.
// Assumes the serial interface supplies one-cycle read and write strobes.
`timescale 1ns/10ps
`default_nettype none
module asil_top
  import asil_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Alert pins, group one.
  input wire logic chip_thermal_warning_i,
  input wire logic lamp_thermal_shutdown_i,
  input wire logic lamp_thermal_warning_i,
  input wire logic lamp_overvoltage_i,
  input wire logic lamp_undervoltage_i,
  input wire logic rail_two_overcurrent_i,
  input wire logic core_rail_overcurrent_i,
  // Alert pins, group two.
  input wire logic lamp_overcurrent_i,
  input wire logic lamp_driver_desaturation_i,
  input wire logic rail_two_desaturation_i,
  // Register port.
  input wire logic [2:0] reg_idx_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Interrupt line.
  output logic irq_out_n_o
);
  // ----------------------------------------
  // Alert synchroniser and bit mapping.
  // ----------------------------------------
  typedef struct packed {
    logic [9:0] s1;
    logic [9:0] s2;
    logic [7:0] en_one;
    logic [7:0] en_two;
    logic [7:0] rdata;
    logic irq;
  } asil_state_t;
  asil_state_t st, next_st;
  logic [ASIL_W_ONE-1:0] raw_one, al_one, r1, f1, re1;
  logic [ASIL_W_TWO-1:0] raw_two, al_two, r2, f2, re2;
  logic rd_set1, rd_set2, rd_clr1, rd_clr2;
  logic wr_en1, wr_en2, irq_hit;
  // ----------------------------------------
  // Decoding helpers.
  // ----------------------------------------
  // Strobe aimed at one register index.
  function automatic logic asil_hit(input logic strobe, input logic [2:0] idx, input logic [2:0] want);
    return strobe && (idx == want);
  endfunction : asil_hit
  // Any rise event whose enable bit is set.
  function automatic logic asil_irq_any(input logic [7:0] ev, input logic [7:0] en);
    return |(ev & en);
  endfunction : asil_irq_any
  always_comb begin
    raw_one = '0;
    raw_one[ASIL_B_CHIP_TW] = chip_thermal_warning_i;
    raw_one[ASIL_B_LAMP_TSD] = lamp_thermal_shutdown_i;
    raw_one[ASIL_B_LAMP_TW] = lamp_thermal_warning_i;
    raw_one[ASIL_B_LAMP_OV] = lamp_overvoltage_i;
    raw_one[ASIL_B_LAMP_UV] = lamp_undervoltage_i;
    raw_one[ASIL_B_RAIL2_OC] = rail_two_overcurrent_i;
    raw_one[ASIL_B_CORE_OC] = core_rail_overcurrent_i;
    raw_two = '0;
    raw_two[ASIL_B_LAMP_OC] = lamp_overcurrent_i;
    raw_two[ASIL_B_LAMP_DSAT] = lamp_driver_desaturation_i;
    raw_two[ASIL_B_RAIL2_DSAT] = rail_two_desaturation_i;
  end
  assign al_one = st.s2[ASIL_W_ONE+ASIL_W_TWO-1:ASIL_W_TWO];
  assign al_two = st.s2[ASIL_W_TWO-1:0];
  assign rd_set1 = asil_hit(reg_rd_i, reg_idx_i, ASIL_IDX_SET_ONE);
  assign rd_set2 = asil_hit(reg_rd_i, reg_idx_i, ASIL_IDX_SET_TWO);
  assign rd_clr1 = asil_hit(reg_rd_i, reg_idx_i, ASIL_IDX_CLR_ONE);
  assign rd_clr2 = asil_hit(reg_rd_i, reg_idx_i, ASIL_IDX_CLR_TWO);
  assign wr_en1 = asil_hit(reg_wr_i, reg_idx_i, ASIL_IDX_EN_ONE);
  assign wr_en2 = asil_hit(reg_wr_i, reg_idx_i, ASIL_IDX_EN_TWO);
  assign irq_hit = asil_irq_any({1'b0, re1}, st.en_one) | asil_irq_any({5'h00, re2}, st.en_two);
  // ----------------------------------------
  // Sticky latches.
  // ----------------------------------------
  // Each latch register has an edge detector of its own, so a read clears
  // only the register that was read.
  asil_edge #(.W(ASIL_W_ONE)) u_rise1 (.core_clk_i(core_clk_i), .rst_i(rst_i), .alert_i(al_one),
    .clr_i(rd_set1), .rise_o(r1), .fall_o(), .rise_ev_o(re1));
  asil_edge #(.W(ASIL_W_ONE)) u_fall1 (.core_clk_i(core_clk_i), .rst_i(rst_i), .alert_i(al_one),
    .clr_i(rd_clr1), .rise_o(), .fall_o(f1), .rise_ev_o());
  asil_edge #(.W(ASIL_W_TWO)) u_rise2 (.core_clk_i(core_clk_i), .rst_i(rst_i), .alert_i(al_two),
    .clr_i(rd_set2), .rise_o(r2), .fall_o(), .rise_ev_o(re2));
  asil_edge #(.W(ASIL_W_TWO)) u_fall2 (.core_clk_i(core_clk_i), .rst_i(rst_i), .alert_i(al_two),
    .clr_i(rd_clr2), .rise_o(), .fall_o(f2), .rise_ev_o());
  // ----------------------------------------
  // Registers and interrupt.
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = {raw_one, raw_two};
    next_st.s2 = st.s1;
    if (wr_en1) begin
      next_st.en_one = reg_wdata_i & ASIL_MASK_ONE;
    end
    if (wr_en2) begin
      next_st.en_two = reg_wdata_i & ASIL_MASK_TWO;
    end
    if (reg_rd_i) begin
      case (reg_idx_i)
        ASIL_IDX_SET_ONE: next_st.rdata = {1'b0, r1};
        ASIL_IDX_SET_TWO: next_st.rdata = {5'h00, r2};
        ASIL_IDX_CLR_ONE: next_st.rdata = {1'b0, f1};
        ASIL_IDX_CLR_TWO: next_st.rdata = {5'h00, f2};
        ASIL_IDX_EN_ONE: next_st.rdata = st.en_one;
        ASIL_IDX_EN_TWO: next_st.rdata = st.en_two;
        default: next_st.rdata = ASIL_ZERO;
      endcase
    end
    // Interrupt pulses when an enabled alert becomes active.
    next_st.irq = irq_hit;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign reg_rdata_o = st.rdata;
  assign irq_out_n_o = ~st.irq;
  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  property p_irq_on_rise;
    @(posedge core_clk_i) disable iff (rst_i)
      asil_irq_any({1'b0, re1}, st.en_one) |=> !irq_out_n_o;
  endproperty
  a_irq_on_rise: assert property (p_irq_on_rise) else $error("Enabled rise gave no interrupt.");
  property p_irq_cause;
    @(posedge core_clk_i) disable iff (rst_i)
      !irq_out_n_o |-> $past(irq_hit);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("Interrupt without enabled rise.");
  property p_mask2;
    @(posedge core_clk_i) disable iff (rst_i)
      (st.en_two == ASIL_ZERO && st.en_one == ASIL_ZERO) |=> irq_out_n_o;
  endproperty
  a_mask2: assert property (p_mask2) else $error("Masked alert gave interrupt.");
  property p_rsv;
    @(posedge core_clk_i) disable iff (rst_i)
      reg_rd_i && reg_idx_i == ASIL_IDX_EN_TWO |=> reg_rdata_o[7:3] == 5'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("Reserved bits not zero.");
  sequence s_fall1;
    !rd_clr1 && al_one[ASIL_B_CHIP_TW] ##1 !al_one[ASIL_B_CHIP_TW];
  endsequence
  property p_fall;
    @(posedge core_clk_i) disable iff (rst_i) s_fall1 |=> f1[ASIL_B_CHIP_TW];
  endproperty
  a_fall: assert property (p_fall) else $error("Fall not latched.");
  property p_rise2;
    @(posedge core_clk_i) disable iff (rst_i) re2[ASIL_B_LAMP_OC] |=> r2[ASIL_B_LAMP_OC];
  endproperty
  a_rise2: assert property (p_rise2) else $error("Rise not latched.");
  property p_clear;
    @(posedge core_clk_i) disable iff (rst_i) rd_set2 && re2 == '0 |=> r2 == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("Read did not clear.");
  property p_map;
    @(posedge core_clk_i) disable iff (rst_i)
      chip_thermal_warning_i |-> ##2 al_one[ASIL_B_CHIP_TW];
  endproperty
  a_map: assert property (p_map) else $error("Bit map wrong.");
  property p_map2;
    @(posedge core_clk_i) disable iff (rst_i)
      lamp_overcurrent_i |-> ##2 al_two[ASIL_B_LAMP_OC];
  endproperty
  a_map2: assert property (p_map2) else $error("Group two map wrong.");
  property p_irq_on_rise2;
    @(posedge core_clk_i) disable iff (rst_i)
      asil_irq_any({5'h00, re2}, st.en_two) |=> !irq_out_n_o;
  endproperty
  a_irq_on_rise2: assert property (p_irq_on_rise2) else $error("Enabled group two rise gave no interrupt.");
  property p_en_wr1;
    @(posedge core_clk_i) disable iff (rst_i)
      wr_en1 |=> st.en_one == ($past(reg_wdata_i) & ASIL_MASK_ONE);
  endproperty
  a_en_wr1: assert property (p_en_wr1) else $error("Group one enable write lost.");
  property p_en_wr2;
    @(posedge core_clk_i) disable iff (rst_i)
      wr_en2 |=> st.en_two == ($past(reg_wdata_i) & ASIL_MASK_TWO);
  endproperty
  a_en_wr2: assert property (p_en_wr2) else $error("Group two enable write lost.");
  property p_rsv_one;
    @(posedge core_clk_i) disable iff (rst_i) reg_rd_i |=> !reg_rdata_o[7];
  endproperty
  a_rsv_one: assert property (p_rsv_one) else $error("Reserved top bit not zero.");
  property p_ro_latch;
    @(posedge core_clk_i) disable iff (rst_i)
      asil_hit(reg_wr_i, reg_idx_i, ASIL_IDX_SET_ONE) && !reg_rd_i && re1 == '0 |=> r1 == $past(r1);
  endproperty
  a_ro_latch: assert property (p_ro_latch) else $error("Write changed a read-only latch.");
  property p_rd_one;
    @(posedge core_clk_i) disable iff (rst_i) rd_set1 |=> reg_rdata_o == {1'b0, $past(r1)};
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("Read data is not the latched bits.");
  sequence s_rise_on_read;
    rd_set2 && re2[ASIL_B_LAMP_OC];
  endsequence
  property p_set_wins;
    @(posedge core_clk_i) disable iff (rst_i) s_rise_on_read |=> r2[ASIL_B_LAMP_OC];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Read clear beat a new event.");
endmodule : asil_top
`default_nettype wire

// ===== include/asil_pkg.sv
// Package for the alert status and interrupt enable logic.
// Assumes a simple register port supplied by the serial interface block.
package asil_pkg;
  // ----------------------------------------
  // Register indices on the register port.
  // ----------------------------------------
  localparam logic [2:0] ASIL_IDX_SET_ONE = 3'h0;
  localparam logic [2:0] ASIL_IDX_SET_TWO = 3'h1;
  localparam logic [2:0] ASIL_IDX_CLR_ONE = 3'h2;
  localparam logic [2:0] ASIL_IDX_CLR_TWO = 3'h3;
  localparam logic [2:0] ASIL_IDX_EN_ONE = 3'h4;
  localparam logic [2:0] ASIL_IDX_EN_TWO = 3'h5;
  // ----------------------------------------
  // Field layouts and reset values.
  // ----------------------------------------
  localparam int ASIL_W_ONE = 7;
  localparam int ASIL_W_TWO = 3;
  localparam logic [7:0] ASIL_MASK_ONE = 8'h7F;
  localparam logic [7:0] ASIL_MASK_TWO = 8'h07;
  localparam logic [7:0] ASIL_RST = 8'h00;
  localparam logic [7:0] ASIL_ZERO = 8'h00;
  // Bit positions, group one.
  localparam int ASIL_B_CHIP_TW = 6;
  localparam int ASIL_B_LAMP_TSD = 5;
  localparam int ASIL_B_LAMP_TW = 4;
  localparam int ASIL_B_LAMP_OV = 3;
  localparam int ASIL_B_LAMP_UV = 2;
  localparam int ASIL_B_RAIL2_OC = 1;
  localparam int ASIL_B_CORE_OC = 0;
  // Bit positions, group two.
  localparam int ASIL_B_LAMP_OC = 2;
  localparam int ASIL_B_LAMP_DSAT = 1;
  localparam int ASIL_B_RAIL2_DSAT = 0;
endpackage : asil_pkg

// ===== src/asil_edge.sv
// Sticky edge latch for one group of alert bits.
// Assumes alerts already synchronised to core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module asil_edge
  import asil_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Alert levels and read clear.
  input wire logic [W-1:0] alert_i,
  input wire logic clr_i,
  // Latched edges and the unlatched rise event.
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o,
  output logic [W-1:0] rise_ev_o
);
  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } asil_edge_t;
  asil_edge_t st, next_st;
  logic [W-1:0] rev, fev;
  always_comb begin
    rev = alert_i & ~st.prev;
    fev = ~alert_i & st.prev;
    next_st = st;
    next_st.prev = alert_i;
    next_st.rise = (clr_i ? '0 : st.rise) | rev;
    next_st.fall = (clr_i ? '0 : st.fall) | fev;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign rise_o = st.rise;
  assign fall_o = st.fall;
  assign rise_ev_o = rev;
endmodule : asil_edge
`default_nettype wire

// ===== verif/asil_mcu_model.sv
// Microcontroller model: register accesses and interrupt line monitor.
// Assumes the register port takes a strobe at the rising edge.
`timescale 1ns/10ps
`default_nettype none
module asil_mcu_model
  import asil_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Device answers.
  input wire logic [7:0] reg_rdata_i,
  input wire logic irq_out_n_i,
  // Register requests.
  output logic [2:0] reg_idx_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o
);
  int irq_seen = 0;
  initial begin
    reg_idx_o = 3'h0;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // Counts low cycles of the interrupt line.
  always @(posedge core_clk_i) begin
    if (!rst_i && irq_out_n_i === 1'b0) begin
      irq_seen++;
    end
  end
  // One strobe per access; the data bus is inverted once released.
  task automatic access(input logic w, input logic [2:0] i, input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk_i);
    reg_idx_o = i;
    reg_wr_o = w;
    reg_rd_o = ~w;
    reg_wdata_o = d;
    @(negedge core_clk_i);
    q = reg_rdata_i;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask : access
endmodule : asil_mcu_model
`default_nettype wire

// ===== verif/alert_status_interrupt_logic_bench.sv
// Self-checking bench for the alert latches, enables and interrupt line.
// Assumes the package and the microcontroller model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module alert_status_interrupt_logic_bench
  import asil_pkg::*;
;
  typedef struct packed {logic [3:0] k; logic en;} asil_row_t;
  asil_row_t rows [10] = '{'{4'h0, 1'b1}, '{4'h1, 1'b0}, '{4'h2, 1'b1}, '{4'h3, 1'b0}, '{4'h4, 1'b1},
                           '{4'h5, 1'b0}, '{4'h6, 1'b1}, '{4'h7, 1'b0}, '{4'h8, 1'b1}, '{4'h9, 1'b0}};
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] al = 10'h000;
  logic [2:0] idx;
  logic rd, wr, irq_n, g2;
  logic [7:0] wd, rdata, v, m, wv;
  int err_count = 0, n_checks = 0, cyc = 0, n0;
  always #5 core_clk_i = ~core_clk_i;
  asil_top asil_top_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .chip_thermal_warning_i(al[9]), .lamp_thermal_shutdown_i(al[8]), .lamp_thermal_warning_i(al[7]),
    .lamp_overvoltage_i(al[6]), .lamp_undervoltage_i(al[5]), .rail_two_overcurrent_i(al[4]),
    .core_rail_overcurrent_i(al[3]), .lamp_overcurrent_i(al[2]), .lamp_driver_desaturation_i(al[1]),
    .rail_two_desaturation_i(al[0]), .reg_idx_i(idx), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd),
    .reg_rdata_o(rdata), .irq_out_n_o(irq_n));
  asil_mcu_model asil_mcu_model_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_rdata_i(rdata),
    .irq_out_n_i(irq_n), .reg_idx_o(idx), .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wd));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [2:0] i, input logic [7:0] e);
    asil_mcu_model_i.access(1'b0, i, 8'h00, v);
    chk("register", e, v);
  endtask : rdc
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(negedge core_clk_i);
    rst_i = 1'b0;
    // ----------------------------------------
    // Row loop: one alert per row, enabled or masked.
    // ----------------------------------------
    foreach (rows[r]) begin
      g2 = rows[r].k < 3;
      m = 8'h01 << (g2 ? rows[r].k : rows[r].k - 4'h3);
      wv = rows[r].en ? 8'hFF : ~m;
      asil_mcu_model_i.access(1'b1, g2 ? ASIL_IDX_EN_TWO : ASIL_IDX_EN_ONE, wv, v);
      rdc(g2 ? ASIL_IDX_EN_TWO : ASIL_IDX_EN_ONE, wv & (g2 ? ASIL_MASK_TWO : ASIL_MASK_ONE));
      n0 = asil_mcu_model_i.irq_seen;
      al[rows[r].k] = 1'b1;
      repeat (6) @(negedge core_clk_i);
      chk("irq pulses", {7'h00, rows[r].en}, 8'(asil_mcu_model_i.irq_seen - n0));
      rdc(g2 ? ASIL_IDX_SET_TWO : ASIL_IDX_SET_ONE, m);
      rdc(g2 ? ASIL_IDX_CLR_TWO : ASIL_IDX_CLR_ONE, 8'h00);
      al[rows[r].k] = 1'b0;
      repeat (6) @(negedge core_clk_i);
      rdc(g2 ? ASIL_IDX_CLR_TWO : ASIL_IDX_CLR_ONE, m);
      rdc(g2 ? ASIL_IDX_CLR_TWO : ASIL_IDX_CLR_ONE, 8'h00);
      rdc(g2 ? ASIL_IDX_SET_TWO : ASIL_IDX_SET_ONE, 8'h00);
    end
    // ----------------------------------------
    // Reset values, reserved indices and read-only latches.
    // ----------------------------------------
    rst_i = 1'b1;
    @(negedge core_clk_i);
    rst_i = 1'b0;
    chk("irq line idle", 8'h01, {7'h00, irq_n});
    for (int i = 0; i < 8; i++) rdc(3'(i), 8'h00);
    asil_mcu_model_i.access(1'b1, ASIL_IDX_SET_ONE, 8'hFF, v);
    rdc(ASIL_IDX_SET_ONE, 8'h00);
    // Masked alerts give no pulse once enables are cleared.
    n0 = asil_mcu_model_i.irq_seen;
    al = 10'h3FF;
    repeat (6) @(negedge core_clk_i);
    chk("masked irq", 8'h00, 8'(asil_mcu_model_i.irq_seen - n0));
    rdc(ASIL_IDX_SET_ONE, ASIL_MASK_ONE);
    rdc(ASIL_IDX_SET_TWO, ASIL_MASK_TWO);
    // Event in the cycle of the read clear must survive the read.
    al[2] = 1'b0;
    repeat (6) @(negedge core_clk_i);
    al[2] = 1'b1;
    @(negedge core_clk_i);
    rdc(ASIL_IDX_SET_TWO, 8'h00);
    rdc(ASIL_IDX_SET_TWO, 8'h04);
    al[9] = 1'b0;
    @(negedge core_clk_i);
    rdc(ASIL_IDX_CLR_ONE, 8'h00);
    rdc(ASIL_IDX_CLR_ONE, 8'h40);
    stop_test();
  end
endmodule : alert_status_interrupt_logic_bench
`default_nettype wire
